// file: hw/itio_override.sv
// module: integration test override of the access-fault interrupt output
`timescale 1ns/1ps
// Overview of operation
// - With test mode off, writes to the test output register are dropped.
// - With test mode off, reads of the test output register return zero.
// - With test mode on, bit 0 written as 1 or 0 sets the interrupt level.
// - Test mode on: a read returns the last written drive bit in bit 0.
// - Software writes zero to bits 31:1; those bits read as zero here.
// - All flip-flops run on the single core clock.
// - The register slave advances only on edges where its enable is high.
// - Reset is active low and holds all logic while low.
// - Control register bit 0 enables test mode when 1, disables when 0.
// - Every register bit, the drive bit included, clears to 0 on reset.
// - Normally the interrupt is high when an access has been refused.
module itio_override
    import itio_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // register slave clock enable from the clock generator
    input  wire logic      reg_clk_en,
    // register bus
    input  wire itio_req_t bus_req,
    output itio_rsp_t      bus_rsp,
    // region checker fault events
    input  wire logic      fault_set,
    input  wire logic      fault_clr,
    // interrupt to the interrupt controller
    output logic           fault_irq
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic        test_en_q;
    logic        test_en_d;
    logic        drive_q;
    logic        drive_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        fault_lvl;
    logic        access;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit_ctrl;
    logic        hit_out;

    // one address decode serves both registers; upper alias bits ignored
    function automatic logic reg_hit(logic [31:0] addr, logic [31:0] ofs);
        return (addr & ITIO_ADDR_MASK) == ofs;
    endfunction : reg_hit

    // access phase only counts on enabled edges
    assign access   = reg_clk_en & bus_req.sel & bus_req.enable;
    assign wr_acc   = access & bus_req.write;
    assign rd_acc   = access & ~bus_req.write;
    assign hit_ctrl = reg_hit(bus_req.addr, ITIO_CTRL_OFS);
    assign hit_out  = reg_hit(bus_req.addr, ITIO_OUT_OFS);

    // ------------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------------
    // control bit is always writable; upper bits are ignored
    assign test_en_d = (wr_acc & hit_ctrl)
                     ? bus_req.wdata[ITIO_EN_BIT] : test_en_q;
    // drive bit only takes writes while test mode is on
    assign drive_d = (wr_acc & hit_out & test_en_q)
                   ? bus_req.wdata[ITIO_DRV_BIT]
                   : drive_q;

    // read data: upper bits zero, output reg zero unless test mode
    always_comb begin
        rdata_d = rdata_q;
        if (rd_acc) begin
            rdata_d = ITIO_ZERO;
            if (hit_ctrl) begin
                rdata_d[ITIO_EN_BIT] = test_en_q;
            end else if (hit_out && test_en_q) begin
                rdata_d[ITIO_DRV_BIT] = drive_q;
            end else begin
                rdata_d = ITIO_ZERO;
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // all state on the core clock, cleared by the active-low reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_en_q <= ITIO_EN_RST;
            drive_q   <= ITIO_DRV_RST;
            rdata_q   <= ITIO_ZERO;
        end else begin
            test_en_q <= test_en_d;
            drive_q   <= drive_d;
            rdata_q   <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // normal fault logic
    // ------------------------------------------------------------------
    itio_fault_flag u_fault (
        .clk       (clk),
        .rst_n     (rst_n),
        .fault_set (fault_set),
        .fault_clr (fault_clr),
        .fault_q   (fault_lvl)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // zero wait states: ready is the enable itself, so a stalled enable
    // stretches the access; data comes from the flop loaded this edge,
    // so reads are sampled by the master one enabled edge after ready
    assign bus_rsp.ready  = reg_clk_en;
    assign bus_rsp.slverr = 1'h0;
    assign bus_rsp.rdata  = rdata_q;
    // mux between the test override and the held fault level
    assign fault_irq = test_en_q ? drive_q : fault_lvl;

    // ------------------------------------------------------------------
    // checks: test output register and read data
    // ------------------------------------------------------------------
    // a drive bit that moves without a test write would fake an interrupt
    ignore_wr_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !test_en_q |=> $stable(drive_q))
        else $error("drive bit changed while test mode off");
    drv_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(wr_acc && hit_out) |=> $stable(drive_q))
        else $error("drive bit changed without a write");
    zero_rd_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_acc && hit_out && !test_en_q) |=> rdata_q == ITIO_ZERO)
        else $error("test output read nonzero while mode off");
    drive_irq_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && hit_out && test_en_q) |=>
            fault_irq == $past(bus_req.wdata[ITIO_DRV_BIT]))
        else $error("interrupt does not follow written drive bit");
    read_back_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_acc && hit_out && test_en_q) |=> rdata_q[0] == $past(drive_q))
        else $error("read back differs from drive bit");
    upper_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rdata_q[31:1] == 31'h0000_0000)
        else $error("upper read bits not zero");
    // unmapped words read as zero so software never sees stale data
    unmap_rd_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_acc && !hit_ctrl && !hit_out) |=> rdata_q == ITIO_ZERO)
        else $error("unmapped read nonzero");

    // ------------------------------------------------------------------
    // checks: register slave and control register
    // ------------------------------------------------------------------
    gated_bus_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !reg_clk_en |=> $stable(test_en_q) && $stable(rdata_q))
        else $error("register moved on a disabled edge");
    rd_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd_acc |=> $stable(rdata_q))
        else $error("read data moved without a read");
    ready_en_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        bus_rsp.ready == reg_clk_en)
        else $error("ready differs from slave enable");
    no_err_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        bus_rsp.slverr == 1'h0)
        else $error("error response raised");
    ctrl_wr_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && hit_ctrl) |=> test_en_q == $past(bus_req.wdata[0]))
        else $error("test enable not written");
    ctrl_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(wr_acc && hit_ctrl) |=> $stable(test_en_q))
        else $error("test enable changed without a write");
    ctrl_rd_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_acc && hit_ctrl) |=> rdata_q[ITIO_EN_BIT] == $past(test_en_q))
        else $error("control read back wrong");

    // ------------------------------------------------------------------
    // checks: interrupt and reset
    // ------------------------------------------------------------------
    irq_mux_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !test_en_q |-> fault_irq == fault_lvl)
        else $error("interrupt not on fault logic in normal mode");
    test_irq_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        test_en_q |-> fault_irq == drive_q)
        else $error("interrupt not on drive bit in test mode");
    fault_set_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fault_set && !test_en_q ##1 !test_en_q) |-> fault_irq)
        else $error("refusal did not raise interrupt");
    // a lone clear must drop the level, or the line would stick high
    clr_drop_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fault_clr && !fault_set && !test_en_q ##1 !test_en_q) |-> !fault_irq)
        else $error("clear did not drop interrupt");
    reset_clr_a: assert property (
        @(posedge clk)
        $rose(rst_n) |-> !test_en_q && !drive_q && !fault_irq)
        else $error("state not cleared by reset");
    rst_hold_a: assert property (
        @(posedge clk)
        !rst_n |-> !test_en_q && !drive_q && !fault_irq && rdata_q == ITIO_ZERO)
        else $error("state not held in reset");

endmodule : itio_override

// file: hw/itio_pkg.sv
// package: register map, field positions and bus types of the test override
package itio_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ITIO_CTRL_OFS    = 32'h0000_0E00;
    localparam logic [31:0] ITIO_OUT_OFS     = 32'h0000_0E08;
    localparam logic [31:0] ITIO_ADDR_MASK   = 32'h0000_0FFC;
    localparam int          ITIO_EN_BIT      = 0;
    localparam int          ITIO_DRV_BIT     = 0;
    localparam logic        ITIO_EN_RST      = 1'h0;
    localparam logic        ITIO_DRV_RST     = 1'h0;
    localparam logic        ITIO_FAULT_RST   = 1'h0;
    localparam logic [31:0] ITIO_ZERO        = 32'h0000_0000;

    // ------------------------------------------------------------------
    // register bus request and answer
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } itio_req_t;

    typedef struct packed {
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } itio_rsp_t;

endpackage : itio_pkg

// file: hw/itio_fault_flag.sv
// module: normal access-fault level held until the region checker drops it
`timescale 1ns/1ps
module itio_fault_flag
    import itio_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // fault events from the region checker
    input  wire logic fault_set,
    input  wire logic fault_clr,
    // held level
    output logic      fault_q
);

    logic fault_d;

    // set wins over a clear in the same cycle so no refusal is lost
    assign fault_d = fault_set | (fault_q & ~fault_clr);

    // flag register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= ITIO_FAULT_RST;
        end else begin
            fault_q <= fault_d;
        end
    end

endmodule : itio_fault_flag

// file: sim/itio_tb_cken.sv
// partner: clock generator making the register slave clock enable
`timescale 1ns/1ps
module itio_tb_cken (
    // core clock
    input  wire logic       clk,
    // division ratio; one keeps the enable tied high
    input  wire logic [1:0] div,
    // enable pulse, aligned to the core clock
    output logic            reg_clk_en
);
    logic [1:0] cnt_q = 2'h0;

    // one pulse every div edges; a ratio of zero is never used
    always_ff @(posedge clk) begin
        cnt_q <= (cnt_q >= div - 2'h1) ? 2'h0 : cnt_q + 2'h1;
    end
    assign reg_clk_en = (cnt_q == 2'h0);
endmodule : itio_tb_cken

// file: sim/testbench.sv
// bench: random and corner accesses to the test override register
`timescale 1ns/1ps
module testbench import itio_pkg::*;;
    logic        clk       = 1'h0;
    logic        rst_n;
    logic        fault_set = 1'h0;
    logic        fault_clr = 1'h0;
    logic [1:0]  div       = 2'h1;
    logic        reg_clk_en;
    logic        fault_irq;
    itio_req_t   bus_req   = '0;
    itio_rsp_t   bus_rsp;
    logic [31:0] rd;
    logic [31:0] seed      = 32'hECD57178;
    int          n_errors  = 0;
    int          num_checks = 0;

    itio_tb_cken itio_tb_cken_i (.clk(clk), .div(div),
        .reg_clk_en(reg_clk_en));
    itio_override itio_override_i (.clk(clk), .rst_n(rst_n),
        .reg_clk_en(reg_clk_en), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .fault_set(fault_set), .fault_clr(fault_clr),
        .fault_irq(fault_irq));

    initial forever #2 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // expected read of the output register; upper bits chosen as zero
    function automatic logic [31:0] exp_out(logic en, logic dq);
        return en ? {31'h0, dq} : ITIO_ZERO;
    endfunction : exp_out

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // request held until ready is seen high; read data the cycle after
    task automatic acc(logic w, logic [31:0] a, logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        bus_req <= '{sel: 1'h1, enable: 1'h0, write: w, addr: a, wdata: d};
        @(posedge clk);
        bus_req.enable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (bus_rsp.ready !== 1'h1 && k < 20);
        if (k >= 20) n_errors++;
        chk("slverr", ITIO_ZERO, {31'h0, bus_rsp.slverr});
        bus_req.sel    <= 1'h0;
        bus_req.enable <= 1'h0;
        #1 rd = bus_rsp.rdata;
    endtask : acc

    task automatic pulse(logic s);
        @(posedge clk);
        fault_set <= s;
        fault_clr <= ~s;
        @(posedge clk);
        fault_set <= 1'h0;
        fault_clr <= 1'h0;
        #1;
    endtask : pulse

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        dq;
        logic        f;
        logic        e;
        // a real falling edge at time zero so the async reset takes hold
        rst_n <= 1'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        acc(0, ITIO_CTRL_OFS, ITIO_ZERO);
        chk("ctrl", ITIO_ZERO, rd);
        acc(1, ITIO_OUT_OFS, 32'h1);
        chk("irq", ITIO_ZERO, {31'h0, fault_irq});
        acc(0, ITIO_OUT_OFS, ITIO_ZERO);
        chk("out", ITIO_ZERO, rd);
        pulse(1'h1);
        chk("irq", 32'h1, {31'h0, fault_irq});
        pulse(1'h0);
        chk("irq", ITIO_ZERO, {31'h0, fault_irq});
        acc(1, ITIO_CTRL_OFS, 32'h1);
        acc(0, ITIO_CTRL_OFS, ITIO_ZERO);
        chk("ctrl", 32'h1, rd);
        acc(0, ITIO_OUT_OFS, ITIO_ZERO);
        chk("out", ITIO_ZERO, rd);
        dq = 1'h0;
        f = 1'h0;
        // random mode, drive bit, enable ratio and fault events
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            div <= r[2] ? 2'h3 : 2'h1;
            acc(1, ITIO_CTRL_OFS, {31'h0, r[0]});
            acc(1, ITIO_OUT_OFS, {31'h0, r[1]});
            if (r[0]) dq = r[1];
            if (r[3]) f = r[4];
            if (r[3]) pulse(r[4]);
            e = r[0] ? dq : f;
            chk("irq", {31'h0, e}, {31'h0, fault_irq});
            acc(0, ITIO_OUT_OFS, ITIO_ZERO);
            chk("out", exp_out(r[0], dq), rd);
        end
        // reset in mid-run with the drive bit set
        acc(1, ITIO_CTRL_OFS, 32'h1);
        acc(1, ITIO_OUT_OFS, 32'h1);
        rst_n <= 1'h0;
        #1 chk("irq", ITIO_ZERO, {31'h0, fault_irq});
        @(posedge clk);
        rst_n <= 1'h1;
        acc(0, ITIO_CTRL_OFS, ITIO_ZERO);
        chk("ctrl", ITIO_ZERO, rd);
        acc(1, ITIO_CTRL_OFS, 32'h1);
        acc(0, ITIO_OUT_OFS, ITIO_ZERO);
        chk("out", ITIO_ZERO, rd);
        report_and_stop();
    end
endmodule : testbench
